// ---- adc_serial_ctrl.sv ----
// Implementation choices: strobed register access and the register addresses.
`timescale 1ns/10ps
module adc_serial_ctrl
   import adc_serial_pkg::*;
(
   input wire logic mclk, // Master clock, 20 MHz
   input wire logic rstn, // Async reset, active low
   input wire logic mode_strap, // Interface mode strap pin
   input wire logic cal_strobe, // Calibration strobe pin
   input wire logic cal_select_a, // Calibration select A pin
   input wire logic cal_select_b, // Calibration select B pin
   input wire logic polarity_select, // High selects bipolar
   input wire logic chip_select_n, // Chip select pin
   input wire logic sclk_in, // Serial clock from partner
   input wire logic sample_valid, // Core result valid
   input wire logic [WORD_W-1:0] sample_data, // Core result, two's complement
   output logic sample_ready, // Buffer can take a result
   output logic serial_data_out, // Serial data pin output
   output logic serial_data_oe, // Serial data pin enable
   output logic sclk_out, // Serial clock pin output
   output logic sclk_oe, // Serial clock pin enable
   output logic data_ready_n, // Word held, active low
   output logic cal_reset, // Converter held in reset
   output logic cal_start, // Calibration start pulse
   output logic cal_system, // Calibration is system type
   output logic cal_kind_a, // Select A seen at strobe rise
   input wire logic [7:0] reg_addr, // Register byte address
   input wire logic [31:0] reg_wdata, // Register write data
   input wire logic reg_wr, // Write strobe
   input wire logic reg_rd, // Read strobe
   output logic [31:0] reg_rdata // Read data, cycle after strobe
);

   state_s st_ff;
   state_s nxt_st;
   logic ext_mode;
   logic shift_evt;
   logic push;
   logic pop;
   logic [WORD_W-1:0] conv;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.mode_s1 = mode_strap;
      nxt_st.mode_s2 = st_ff.mode_s1;
      nxt_st.cal_s1 = cal_strobe;
      nxt_st.cal_s2 = st_ff.cal_s1;
      nxt_st.cal_d = st_ff.cal_s2;
      nxt_st.csn_s1 = chip_select_n;
      nxt_st.csn_s2 = st_ff.csn_s1;
      nxt_st.sck_s1 = sclk_in;
      nxt_st.sck_s2 = st_ff.sck_s1;
      nxt_st.sck_d = st_ff.sck_s2;
      nxt_st.sela_s1 = cal_select_a;
      nxt_st.sela_s2 = st_ff.sela_s1;
      nxt_st.selb_s1 = cal_select_b;
      nxt_st.selb_s2 = st_ff.selb_s1;
      nxt_st.pol_s1 = polarity_select;
      nxt_st.pol_s2 = st_ff.pol_s1;
      nxt_st.cal_go = 1'b0;
      nxt_st.rdata = 32'h0;

      ext_mode = ~st_ff.mode_s2;
      // Data moves on the falling serial clock in both modes
      shift_evt = ext_mode ? (st_ff.sck_d & ~st_ff.sck_s2) : (st_ff.div == SCLK_HIGH_PHASE);
      conv = st_ff.pol_s2 ? {~sample_data[WORD_W-1], sample_data[WORD_W-2:0]} : sample_data;
      push = sample_valid & st_ff.in_ready;
      pop = 1'b0;

      // Calibration strobe
      if (st_ff.cal_s2 & ~st_ff.cal_d)
      begin
         nxt_st.cal_sys = ~st_ff.selb_s2;
         nxt_st.cal_a = st_ff.sela_s2;
      end
      if (st_ff.cal_s2)
      begin
         if (st_ff.cal_cnt != CAL_HOLD_CYC)
            nxt_st.cal_cnt = st_ff.cal_cnt + 3'h1;
         else
            nxt_st.cal_rst = 1'b1;
      end
      else
      begin
         nxt_st.cal_cnt = 3'h0;
         if (st_ff.cal_rst)
         begin
            nxt_st.cal_rst = 1'b0;
            nxt_st.cal_go = 1'b1;
         end
      end

      // Transfer sequence
      case (st_ff.state)
         ST_IDLE, ST_READY:
         begin
            if (st_ff.buf_cnt != 2'h0)
            begin
               pop = 1'b1;
               nxt_st.shreg = st_ff.buf0;
               nxt_st.hold = st_ff.buf0;
               nxt_st.load_cnt = 3'h1;
               nxt_st.state = ST_LOAD;
            end
            else if (st_ff.state == ST_READY && ~st_ff.csn_s2 && st_ff.ctrl_en)
            begin
               nxt_st.state = ST_SEND;
               nxt_st.bit_cnt = 5'h0;
               nxt_st.div = SCLK_DIV_START;
            end
         end
         ST_LOAD:
         begin
            // Chip select is ignored while a fresh word settles
            if (st_ff.load_cnt == LOAD_HIGH_CYC)
               nxt_st.state = ST_READY;
            else
               nxt_st.load_cnt = st_ff.load_cnt + 3'h1;
         end
         ST_SEND:
         begin
            if (!ext_mode)
               nxt_st.div = st_ff.div + 2'h1;
            if (shift_evt)
            begin
               if (st_ff.bit_cnt == LAST_BIT)
                  nxt_st.state = ST_IDLE;
               else if (st_ff.csn_s2)
               begin
                  // Deselect mid-word: finish the bit, keep the word for a retry
                  nxt_st.state = ST_READY;
                  nxt_st.shreg = st_ff.hold;
               end
               else
               begin
                  nxt_st.shreg = {st_ff.shreg[WORD_W-2:0], 1'b0};
                  nxt_st.bit_cnt = st_ff.bit_cnt + 5'h1;
               end
            end
         end
         default:
            nxt_st.state = ST_IDLE;
      endcase

      // Two-entry buffer
      if (pop)
      begin
         nxt_st.buf0 = st_ff.buf1;
         nxt_st.buf_cnt = st_ff.buf_cnt - 2'h1;
      end
      if (push)
      begin
         if (nxt_st.buf_cnt == 2'h0)
            nxt_st.buf0 = conv;
         else
            nxt_st.buf1 = conv;
         nxt_st.buf_cnt = nxt_st.buf_cnt + 2'h1;
      end

      // Calibration reset flushes every held word
      if (nxt_st.cal_rst)
      begin
         nxt_st.buf_cnt = 2'h0;
         nxt_st.state = ST_IDLE;
      end

      nxt_st.in_ready = (nxt_st.buf_cnt != BUF_DEPTH);
      nxt_st.sdo_oe = (nxt_st.state == ST_SEND);
      nxt_st.sdo = nxt_st.shreg[WORD_W-1];
      nxt_st.sclk_oe = (nxt_st.state == ST_SEND) & ~ext_mode;
      nxt_st.sclk_o = nxt_st.sclk_oe & (nxt_st.div == SCLK_HIGH_PHASE);
      nxt_st.data_ready_n_n = ~(nxt_st.state == ST_READY || nxt_st.state == ST_SEND);

      // Register port
      if (reg_wr && reg_addr == CTRL_ADDR)
         nxt_st.ctrl_en = reg_wdata[CTRL_EN_BIT];
      if (reg_rd)
      begin
         if (reg_addr == CTRL_ADDR)
            nxt_st.rdata = {31'h0, st_ff.ctrl_en};
         else if (reg_addr == STATUS_ADDR)
            nxt_st.rdata = {23'h0, st_ff.state, st_ff.buf_cnt, st_ff.pol_s2,
                            st_ff.cal_a, st_ff.cal_sys, st_ff.cal_rst, ext_mode};
         else if (reg_addr == WORD_ADDR)
            nxt_st.rdata = {12'h0, st_ff.hold};
         else
            nxt_st.rdata = 32'h0;
      end
   end

   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         st_ff <= '0;
         st_ff.state <= ST_IDLE;
         st_ff.ctrl_en <= CTRL_EN_RESET;
         st_ff.data_ready_n_n <= 1'b1;
         st_ff.csn_s1 <= 1'b1;
         st_ff.csn_s2 <= 1'b1;
         st_ff.cal_sys <= 1'b0;
      end
      else
         st_ff <= nxt_st;
   end

   assign sample_ready = st_ff.in_ready;
   assign serial_data_out = st_ff.sdo;
   assign serial_data_oe = st_ff.sdo_oe;
   assign sclk_out = st_ff.sclk_o;
   assign sclk_oe = st_ff.sclk_oe;
   assign data_ready_n = st_ff.data_ready_n_n;
   assign cal_reset = st_ff.cal_rst;
   assign cal_start = st_ff.cal_go;
   assign cal_system = st_ff.cal_sys;
   assign cal_kind_a = st_ff.cal_a;
   assign reg_rdata = st_ff.rdata;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   sequence s_cal_held;
      st_ff.cal_s2 [*5];
   endsequence

   sequence s_load_entry;
      st_ff.state != ST_LOAD ##1 st_ff.state == ST_LOAD;
   endsequence

   a_ext_clock_input: assert property (@(posedge mclk) disable iff (!rstn)
      !st_ff.mode_s2 |-> !sclk_oe)
      else $error("serial clock driven in external mode");

   a_msb_first: assert property (@(posedge mclk) disable iff (!rstn)
      $rose(serial_data_oe) |-> serial_data_out == st_ff.hold[WORD_W-1])
      else $error("first bit is not the MSB");

   a_self_duty: assert property (@(posedge mclk) disable iff (!rstn || cal_reset)
      sclk_out && st_ff.bit_cnt != LAST_BIT && !st_ff.csn_s2
      |=> !sclk_out ##1 !sclk_out ##1 !sclk_out ##1 sclk_out)
      else $error("self clock not one high in four");

   a_cal_sample: assert property (@(posedge mclk) disable iff (!rstn)
      st_ff.cal_s2 && !st_ff.cal_d |=> cal_kind_a == $past(st_ff.sela_s2))
      else $error("select A not taken at strobe rise");

   a_system_cal: assert property (@(posedge mclk) disable iff (!rstn)
      st_ff.cal_s2 && !st_ff.cal_d && !st_ff.selb_s2 |=> cal_system)
      else $error("select B low did not pick system calibration");

   a_offset_binary: assert property (@(posedge mclk) disable iff (!rstn)
      push && st_ff.pol_s2 && st_ff.buf_cnt == 2'h0 && !st_ff.cal_rst
         && st_ff.state == ST_SEND
      |=> st_ff.buf0 == {~$past(sample_data[WORD_W-1]), $past(sample_data[WORD_W-2:0])})
      else $error("bipolar word not offset binary");

   a_cal_reset: assert property (@(posedge mclk) disable iff (!rstn)
      s_cal_held |=> cal_reset)
      else $error("long strobe did not reset");

   a_cal_start: assert property (@(posedge mclk) disable iff (!rstn)
      cal_reset && !st_ff.cal_s2 |=> cal_start && !cal_reset)
      else $error("calibration not started on strobe fall");

   a_cs_start: assert property (@(posedge mclk) disable iff (!rstn)
      st_ff.state == ST_READY && !st_ff.csn_s2 && st_ff.ctrl_en && st_ff.buf_cnt == 2'h0
         && !nxt_st.cal_rst
      |=> serial_data_oe)
      else $error("chip select did not start transfer");

   a_ready_load: assert property (@(posedge mclk) disable iff (!rstn)
      s_load_entry ##0 st_ff.load_cnt == 3'h1 |-> data_ready_n [*4] ##1 (!data_ready_n || cal_reset
         || st_ff.state != ST_READY))
      else $error("ready not high for four on load");

   a_word_length: assert property (@(posedge mclk) disable iff (!rstn)
      st_ff.state == ST_SEND && shift_evt && st_ff.bit_cnt == LAST_BIT && !nxt_st.cal_rst
      |=> !serial_data_oe && data_ready_n)
      else $error("word did not end after twenty bits");

endmodule

// ---- adc_serial_pkg.sv ----
// Summary of operation
// - Strap low: external clock, serial clock input
// - External mode: unformatted word, MSB first
// - Strap high: drive serial clock, quarter rate
// - Calibration selects sampled at strobe rise
// - Select B low: system calibration
// - Bipolar results coded offset binary
// - Strobe held over four cycles: reset, calibrate
// - Chip select low starts serial transfer
// - Ready low while valid; high four on load
// - Each result is one 20-bit serial word
package adc_serial_pkg;

   localparam int WORD_W = 20;
   localparam logic [4:0] LAST_BIT = 5'h13;
   localparam logic [2:0] LOAD_HIGH_CYC = 3'h4;
   localparam logic [2:0] CAL_HOLD_CYC = 3'h4;
   localparam logic [1:0] SCLK_DIV_START = 2'h1;
   localparam logic [1:0] SCLK_HIGH_PHASE = 2'h0;
   localparam logic [1:0] BUF_DEPTH = 2'h2;

   localparam logic [7:0] CTRL_ADDR = 8'h00;
   localparam logic [7:0] STATUS_ADDR = 8'h04;
   localparam logic [7:0] WORD_ADDR = 8'h08;
   localparam int CTRL_EN_BIT = 0;
   localparam logic CTRL_EN_RESET = 1'b1;

   typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_READY, ST_SEND} xfer_e;

   typedef struct packed {
      logic mode_s1;
      logic mode_s2;
      logic cal_s1;
      logic cal_s2;
      logic cal_d;
      logic csn_s1;
      logic csn_s2;
      logic sck_s1;
      logic sck_s2;
      logic sck_d;
      logic sela_s1;
      logic sela_s2;
      logic selb_s1;
      logic selb_s2;
      logic pol_s1;
      logic pol_s2;
      logic [WORD_W-1:0] buf0;
      logic [WORD_W-1:0] buf1;
      logic [1:0] buf_cnt;
      logic in_ready;
      logic [WORD_W-1:0] shreg;
      logic [WORD_W-1:0] hold;
      logic [4:0] bit_cnt;
      xfer_e state;
      logic [2:0] load_cnt;
      logic [1:0] div;
      logic [2:0] cal_cnt;
      logic cal_rst;
      logic cal_go;
      logic cal_sys;
      logic cal_a;
      logic sdo;
      logic sdo_oe;
      logic sclk_o;
      logic sclk_oe;
      logic data_ready_n_n;
      logic ctrl_en;
      logic [31:0] rdata;
   } state_s;

endpackage

// ---- host_model.sv ----
`timescale 1ns/10ps
module host_model (
   input wire logic mclk, // Master clock
   input wire logic sdo, // Serial data pin
   input wire logic oe, // Data pin enable
   input wire logic sck, // Serial clock wire
   output logic csn, // Chip select, active low
   output logic sck_drv // Serial clock drive
);
   logic [19:0] word;
   int bad;
   initial
   begin
      csn = 1'b1;
      sck_drv = 1'b0;
      bad = 0;
   end
   // --------------------------------------------
   // Frame reader; clock idles low between frames
   // --------------------------------------------
   task automatic fetch(input int n, input bit self);
      int t;
      word = 20'h00000;
      #13 csn = 1'b0;
      repeat (self ? 1 : 8) @(posedge mclk);
      // Keep link clock edges clear of the sampling edge
      if (!self) #10;
      for (int i = 0; i < n; i++)
      begin
         if (self)
         begin
            t = 1;
            while (!sck && t < 40)
            begin
               @(negedge mclk);
               t++;
            end
            if ((i > 0 && t != 4) || !oe) bad++;
            word = {word[18:0], sdo};
            @(negedge mclk);
            if (sck) bad++;
         end
         else
         begin
            #200 sck_drv = 1'b1;
            // Late sample: the bit moves only after a synced fall
            #200 word = {word[18:0], sdo};
            if (!oe) bad++;
            sck_drv = 1'b0;
         end
      end
      #100 csn = 1'b1;
      if (n < 20)
      begin
         #100 sck_drv = 1'b1;
         #200 sck_drv = 1'b0;
      end
      repeat (4) @(posedge mclk);
   endtask
endmodule

// ---- testbench.sv ----
`timescale 1ns/10ps
module testbench;
   import adc_serial_pkg::*;
   logic mclk = 1'b0;
   logic rstn = 1'b0;
   logic mode_strap = 1'b0;
   logic cal_strobe = 1'b0;
   logic cal_select_a = 1'b0;
   logic cal_select_b = 1'b0;
   logic polarity_select = 1'b0;
   logic sample_valid = 1'b0;
   logic [WORD_W-1:0] sample_data = 20'h00000;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic sample_ready, serial_data_out, serial_data_oe, sclk_out, sclk_oe, data_ready_n;
   logic cal_reset, cal_start, cal_system, cal_kind_a, csn, sck_drv, sclk_in;
   logic [31:0] reg_rdata;
   logic [19:0] w;
   int error_cnt = 0;
   int checks_done = 0;
   int starts = 0;
   int refused = 0;
   int rst_cyc = 0;
   int r;
   logic sdo_line;
   int hi, s;
   always #25 mclk = ~mclk;
   assign sclk_in = sclk_oe ? sclk_out : sck_drv;
   // Released data pin has no pull: model it as the wrong level
   assign sdo_line = serial_data_oe ? serial_data_out : ~serial_data_out;
   always @(posedge mclk)
   begin
      starts <= starts + int'(cal_start);
      rst_cyc <= rst_cyc + int'(cal_reset);
      refused <= refused + int'(sample_valid && !sample_ready);
   end
   adc_serial_ctrl DUT (.mclk, .rstn, .mode_strap, .cal_strobe, .cal_select_a,
      .cal_select_b, .polarity_select, .chip_select_n(csn), .sclk_in, .sample_valid,
      .sample_data, .sample_ready, .serial_data_out, .serial_data_oe, .sclk_out,
      .sclk_oe, .data_ready_n, .cal_reset, .cal_start, .cal_system, .cal_kind_a,
      .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
   host_model host (.mclk, .sdo(sdo_line), .oe(serial_data_oe), .sck(sclk_in),
      .csn, .sck_drv);
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e)
      begin
         error_cnt++;
         $display("[ERR] %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic bus(input logic [7:0] a, input logic [31:0] d, input bit wr);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= wr;
      reg_rd <= !wr;
      @(posedge mclk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      #1 if (!wr) chk("reg_rdata", d, reg_rdata);
   endtask
   task automatic push(input logic [19:0] d);
      int t = 0;
      @(posedge mclk);
      sample_valid <= 1'b1;
      sample_data <= d;
      do
      begin
         @(negedge mclk);
         t++;
      end
      while (sample_ready !== 1'b1 && t < 400);
      @(posedge mclk);
      sample_valid <= 1'b0;
   endtask
   function automatic logic [31:0] coded(input logic [19:0] d);
      return 32'(polarity_select ? {~d[19], d[18:0]} : d);
   endfunction
   task automatic xfer(input logic [19:0] d, input bit self);
      int t = 0;
      push(d);
      while (data_ready_n !== 1'b0 && t < 60)
      begin
         @(negedge mclk);
         t++;
      end
      chk("data_ready_n", 32'h0, 32'(data_ready_n));
      host.fetch(20, self);
      chk("word", coded(d), 32'(host.word));
      chk("data_ready_n", 32'h1, 32'(data_ready_n));
   endtask
   task automatic conclude();
      $display("Mismatches %0d, checks %0d", error_cnt, checks_done);
      if (error_cnt == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial
   begin
      #1000000;
      error_cnt++;
      conclude();
   end
   // ---------
   // Scenarios
   // ---------
   initial
   begin
      void'($urandom(64));
      repeat (6) @(posedge mclk);
      rstn <= 1'b1;
      #1 chk("data_ready_n", 32'h1, 32'(data_ready_n));
      bus(CTRL_ADDR, 32'h1, 1'b0);
      bus(8'h0C, 32'h0, 1'b0);
      bus(STATUS_ADDR, 32'h1, 1'b0);
      bus(CTRL_ADDR, 32'h0, 1'b1);
      bus(CTRL_ADDR, 32'h0, 1'b0);
      bus(CTRL_ADDR, 32'h1, 1'b1);
      xfer(20'($urandom), 1'b0);
      polarity_select <= 1'b1;
      repeat (3) @(posedge mclk);
      xfer(20'h7FFFF, 1'b0);
      xfer(20'h80000, 1'b0);
      xfer(20'($urandom), 1'b0);
      // Newer word reloads; aborted frame restarts at the top bit
      w = 20'($urandom);
      xfer(20'h12345, 1'b0);
      push(20'h0ABCD);
      repeat (12) @(negedge mclk);
      push(w);
      hi = 0;
      repeat (12) @(negedge mclk) hi += int'(data_ready_n);
      chk("reload_high", 32'h4, 32'(hi));
      host.fetch(7, 1'b0);
      host.fetch(20, 1'b0);
      chk("restart", coded(w), 32'(host.word));
      mode_strap <= 1'b1;
      repeat (4) @(posedge mclk);
      xfer(20'($urandom), 1'b1);
      mode_strap <= 1'b0;
      // Result source stalls in mid-frame once the buffer fills
      push(20'h0F0F0);
      repeat (12) @(posedge mclk);
      s = refused;
      fork
         host.fetch(20, 1'b0);
         begin
            repeat (20) @(posedge mclk);
            push(20'h11111);
            push(20'h22222);
            push(w);
         end
      join
      chk("word", coded(20'h0F0F0), 32'(host.word));
      chk("refused", 32'h1, 32'(refused > s));
      repeat (40) @(posedge mclk);
      host.fetch(20, 1'b0);
      chk("word", coded(w), 32'(host.word));
      bus(WORD_ADDR, coded(w), 1'b0);
      for (int i = 0; i < 4; i++)
      begin
         s = starts;
         r = rst_cyc;
         w[0] = 1'($urandom);
         @(posedge mclk);
         cal_select_a <= w[0];
         cal_select_b <= i[1];
         @(posedge mclk);
         cal_strobe <= 1'b1;
         repeat (i[0] ? 5 : 4) @(posedge mclk);
         cal_strobe <= 1'b0;
         cal_select_a <= ~w[0];
         cal_select_b <= ~i[1];
         repeat (8) @(posedge mclk);
         chk("cal_kind_a", 32'(w[0]), 32'(cal_kind_a));
         chk("cal_system", 32'(i[1] == 1'b0), 32'(cal_system));
         chk("cal_start", 32'(s + i[0]), 32'(starts));
         chk("cal_reset", 32'(r + i[0]), 32'(rst_cyc));
      end
      chk("host_bad", 32'h0, 32'(host.bad));
      conclude();
   end
endmodule
